// File: src/osc_cfg_pkg.sv
// Purpose: constants for the oscillator configuration unit
// Assumes: byte-wide peripheral register access
// Notes:   offsets are byte indices within the peripheral
package osc_cfg_pkg;
  localparam logic [7:0] periph_num          = 8'h04;
  localparam logic [7:0] off_general_ctrl    = 8'h00;
  localparam logic [7:0] off_on_die_ctrl     = 8'h01;
  localparam logic [7:0] off_crystal_ctrl    = 8'h02;
  localparam int         sel_bit             = 0;
  localparam int         reset_on_change_bit = 1;
  localparam int         on_die_enable_bit   = 0;
  localparam int         on_die_slow_bit     = 1;
  localparam int         crystal_enable_bit  = 0;
  localparam int         crystal_bias_bit    = 1;
  localparam logic       rst_reset_on_change = 1'b0;
  localparam logic       rst_on_die_slow     = 1'b0;
  localparam logic       rst_on_die_enable   = 1'b1;
  localparam logic       rst_crystal_bias    = 1'b1;
  localparam logic       rst_crystal_enable  = 1'b1;
  localparam int         tile_reset_cycles   = 4;
endpackage

// File: src/osc_cfg_if.sv
// Purpose: carries a tile reset request from the register file to the pulse timer
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface tile_reset_if;
  logic start;
  modport requester (output start);
  modport timer     (input start);
endinterface
`default_nettype wire

// File: src/tile_reset_timer.sv
// Purpose: stretches a start pulse into a tile reset lasting a fixed cycle count
// Assumes: start is a one-cycle pulse on mclk
// Notes:   a start while busy restarts the count so the reset is never cut short
`timescale 1ns/1ps
`default_nettype none
module tile_reset_timer #(
  parameter int cycles = osc_cfg_pkg::tile_reset_cycles
) (
  input  wire logic    mclk,
  input  wire logic    rst_n,
  tile_reset_if.timer  req,
  output var  logic    tile_reset_q
);
  // the count register is eight bits wide and a zero length pulse would never reset the tile
  if (cycles < 1 || cycles > 255) begin : g_bad_cycles
    $error("tile_reset_timer: cycles out of range");
  end
  logic [7:0] count_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_q      <= 8'h00;
      tile_reset_q <= 1'b0;
    end else if (req.start) begin
      count_q      <= 8'(cycles - 1);
      tile_reset_q <= 1'b1;
    end else if (count_q != 8'h00) begin
      count_q <= count_q - 8'h01;
    end else begin
      tile_reset_q <= 1'b0;
    end
  end
endmodule // tile_reset_timer
`default_nettype wire

// File: src/osc_cfg_unit.sv
// Purpose: oscillator source select and enable registers, peripheral four
// Assumes: byte-wide register port synchronous to mclk; sel_pin stable around reset
// Notes:   read data is registered, valid the cycle after rd_en
`timescale 1ns/1ps
`default_nettype none
module osc_cfg_unit (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       sel_pin,
  input  wire logic [7:0] periph,
  input  wire logic [7:0] addr,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_en,
  output var  logic [7:0] rd_data_q,
  output var  logic       rd_valid_q,
  output var  logic       use_on_die_q,
  output var  logic       on_die_enable_q,
  output var  logic       on_die_slow_q,
  output var  logic       crystal_enable_q,
  output var  logic       crystal_bias_q,
  output var  logic       tile_reset_q
);
  tile_reset_if rst_req ();

  logic hit;
  logic wr_gen;
  logic wr_on_die;
  logic wr_crystal;
  logic reset_on_change_q;
  logic strap_pending_q;

  // only this peripheral number answers; others belong to neighbouring units
  assign hit        = (periph == osc_cfg_pkg::periph_num);
  assign wr_gen     = hit && wr_en && addr == osc_cfg_pkg::off_general_ctrl;
  assign wr_on_die  = hit && wr_en && addr == osc_cfg_pkg::off_on_die_ctrl;
  assign wr_crystal = hit && wr_en && addr == osc_cfg_pkg::off_crystal_ctrl;

  // the strap is caught on the first edge after reset release, not inside reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strap_pending_q <= 1'b1;
      use_on_die_q    <= 1'b0;
    end else if (strap_pending_q) begin
      strap_pending_q <= 1'b0;
      use_on_die_q    <= sel_pin;
    end else if (wr_gen) begin
      use_on_die_q <= wr_data[osc_cfg_pkg::sel_bit];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reset_on_change_q <= osc_cfg_pkg::rst_reset_on_change;
    end else if (wr_gen) begin
      reset_on_change_q <= wr_data[osc_cfg_pkg::reset_on_change_bit];
    end
  end

  // the option as it stood before this write decides; a write setting both at once does not reset
  assign rst_req.start = wr_gen && !strap_pending_q && reset_on_change_q
                         && (wr_data[osc_cfg_pkg::sel_bit] != use_on_die_q);

  tile_reset_timer #(.cycles(osc_cfg_pkg::tile_reset_cycles)) u_timer (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .req          (rst_req.timer),
    .tile_reset_q (tile_reset_q)
  );

  // enables are not interlocked with the select: software owns that ordering
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      on_die_slow_q   <= osc_cfg_pkg::rst_on_die_slow;
      on_die_enable_q <= osc_cfg_pkg::rst_on_die_enable;
    end else if (wr_on_die) begin
      on_die_slow_q   <= wr_data[osc_cfg_pkg::on_die_slow_bit];
      on_die_enable_q <= wr_data[osc_cfg_pkg::on_die_enable_bit];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      crystal_bias_q   <= osc_cfg_pkg::rst_crystal_bias;
      crystal_enable_q <= osc_cfg_pkg::rst_crystal_enable;
    end else if (wr_crystal) begin
      crystal_bias_q   <= wr_data[osc_cfg_pkg::crystal_bias_bit];
      crystal_enable_q <= wr_data[osc_cfg_pkg::crystal_enable_bit];
    end
  end

  // reserved bits and unmapped offsets read as zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= hit && rd_en;
      rd_data_q  <= 8'h00;
      if (hit && rd_en) begin
        unique case (addr)
          osc_cfg_pkg::off_general_ctrl: begin
            rd_data_q <= {6'h00, reset_on_change_q, use_on_die_q};
          end
          osc_cfg_pkg::off_on_die_ctrl: begin
            rd_data_q <= {6'h00, on_die_slow_q, on_die_enable_q};
          end
          osc_cfg_pkg::off_crystal_ctrl: begin
            rd_data_q <= {6'h00, crystal_bias_q, crystal_enable_q};
          end
          default: begin
            rd_data_q <= 8'h00;
          end
        endcase
      end
    end
  end
endmodule // osc_cfg_unit
`default_nettype wire

// File: verification/osc_cfg_props.sv
// Purpose: port assertions for osc_cfg_unit
// Assumes: a retrigger inside a tile reset pulse only stretches it
// Notes:   roc_q mirrors the reset-on-change bit, which has no port
`timescale 1ns/1ps
`default_nettype none
module osc_cfg_props (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       sel_pin,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic       rd_valid_q,
  input wire logic       use_on_die_q,
  input wire logic       on_die_enable_q,
  input wire logic       on_die_slow_q,
  input wire logic       crystal_enable_q,
  input wire logic       crystal_bias_q,
  input wire logic       tile_reset_q,
  input wire logic [7:0] periph,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic roc_q;
  wire  w4   = wr_en && periph == 8'h04;
  wire  trig = w4 && addr == 8'h00 && roc_q && wr_data[0] != use_on_die_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) roc_q <= 1'b0;
    else if (w4 && addr == 8'h00) roc_q <= wr_data[1];
  end
  sequence pulse_s; tile_reset_q [*4]; endsequence
  sequence quiet_s; (!trig) [*4]; endsequence
  strap_sel_a: assert property ($past(rst_n) && !$past(rst_n, 2) |-> use_on_die_q == $past(sel_pin))
    else $error("strap select");
  rd_answer_a: assert property (rd_valid_q == $past(rd_en && periph == 8'h04)) else $error("read valid");
  rd_unmapped_a: assert property (rd_en && periph == 8'h04 && addr > 8'h02
    |=> rd_data_q == 8'h00) else $error("unmapped read");
  src_write_a: assert property (w4 && addr == 8'h00 |=> use_on_die_q == $past(wr_data[0]))
    else $error("select");
  od_write_a: assert property (w4 && addr == 8'h01
    |=> {on_die_slow_q, on_die_enable_q} == $past(wr_data[1:0])) else $error("on-die");
  xtal_write_a: assert property (w4 && addr == 8'h02
    |=> {crystal_bias_q, crystal_enable_q} == $past(wr_data[1:0])) else $error("crystal");
  regs_hold_a: assert property ($past(rst_n) && !w4 |=> $stable({use_on_die_q, on_die_enable_q,
    on_die_slow_q, crystal_enable_q, crystal_bias_q})) else $error("changed without write");
  tile_pulse_a: assert property (trig |=> pulse_s) else $error("tile pulse");
  tile_end_a: assert property (trig ##1 quiet_s |=> !tile_reset_q) else $error("tile pulse end");
  tile_cause_a: assert property ($rose(tile_reset_q) |-> $past(trig)) else $error("tile cause");
endmodule // osc_cfg_props
bind osc_cfg_unit osc_cfg_props u_props (.*);
`default_nettype wire

// File: verification/tb.sv
// Purpose: self-checking bench for osc_cfg_unit
// Assumes: inputs driven on the falling edge
// Notes:   random general-control writes keep reset-on-change clear
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       mclk = 1'b0, rst_n = 1'b0, sel_pin = 1'b1, wr_en = 1'b0, rd_en = 1'b0, rd_valid_q, use_on_die_q;
  logic       on_die_enable_q, on_die_slow_q, crystal_enable_q, crystal_bias_q, tile_reset_q;
  logic [7:0] periph = 8'h04, addr = 8'h00, wr_data = 8'h00, rd_data_q, a, d, m [4];
  int         fails = 0, comparisons = 0, cyc = 0;
  integer     seed = 23;
  // the bench board feeds an external oscillator into the crystal input, so the bias may go off
  localparam logic ext_osc = 1'b1;
  always #4 mclk = ~mclk;
  osc_cfg_unit u_dut (.*);
  task automatic check(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] ad, p);
    return (p == 8'h04 && ad < 8'h03) ? m[ad[1:0]] : 8'h00;
  endfunction
  task automatic acc(input logic w, r, input logic [7:0] ad, dt, p);
    logic [7:0] e;
    e = exp_rd(ad, p);
    @(negedge mclk);
    {wr_en, rd_en, addr, wr_data, periph} = {w, r, ad, dt, p};
    if (w && p == 8'h04 && ad < 8'h03) m[ad[1:0]] = dt & 8'h03;
    @(negedge mclk);
    {wr_en, rd_en} = 2'b00;
    if (r) check({7'h00, rd_valid_q}, {7'h00, p == 8'h04});
    if (r) check(rd_data_q, e);
    check({3'h0, use_on_die_q, on_die_enable_q, on_die_slow_q, crystal_enable_q, crystal_bias_q},
          {3'h0, m[0][0], m[1][0], m[1][1], m[2][0], m[2][1]});
  endtask
  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      $display("Error %0t timeout", $time);
      close_out();
    end
  end
  initial begin
    m = '{8'h01, 8'h01, 8'h03, 8'h00};
    repeat (2) @(negedge mclk);
    rst_n = 1;
    for (int i = 0; i < 4; i++) acc(0, 1, 8'(i), 8'h00, 8'h04);
    acc(1, 1, 8'h01, 8'h00, 8'h05);
    acc(1, 1, 8'hFF, 8'hFF, 8'h04);
    $display("test reset done");
    acc(1, 0, 8'h00, 8'h00, 8'h04);
    acc(1, 0, 8'h00, 8'h03, 8'h04);
    check({7'h00, tile_reset_q}, 8'h00);
    acc(1, 0, 8'h00, 8'h02, 8'h04);
    repeat (4) begin
      check({7'h00, tile_reset_q}, 8'h01);
      @(negedge mclk);
    end
    check({7'h00, tile_reset_q}, 8'h00);
    acc(1, 0, 8'h00, 8'h03, 8'h04);
    check({7'h00, tile_reset_q}, 8'h01);
    acc(1, 0, 8'h00, 8'h02, 8'h04);
    repeat (4) begin
      check({7'h00, tile_reset_q}, 8'h01);
      @(negedge mclk);
    end
    check({7'h00, tile_reset_q}, 8'h00);
    acc(1, 0, 8'h00, 8'h00, 8'h04);
    check({7'h00, tile_reset_q}, 8'h00);
    $display("test tile reset done");
    for (int i = 0; i < 300; i++) begin
      sel_pin = 1'($random(seed));
      a = 8'($random(seed)) & 8'h03;
      d = 8'($random(seed)) & ((a == 8'h00) ? 8'h01 : 8'hFF);
      if (a == 8'h00 && !m[d[0] ? 1 : 2][0]) d[0] = m[0][0];
      if (a == 8'h01 && m[0][0]) d[0] = 1'b1;
      if (a == 8'h02 && !m[0][0]) d[0] = 1'b1;
      if (a == 8'h02 && !ext_osc) d[1] = 1'b1;
      acc(1'($random(seed)), 1'($random(seed)), a, d, (($random(seed) & 7) == 0) ? 8'h05 : 8'h04);
    end
    $display("test random done");
    sel_pin = 1'b0;
    rst_n   = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    m = '{8'h00, 8'h01, 8'h03, 8'h00};
    for (int i = 0; i < 3; i++) acc(0, 1, 8'(i), 8'h00, 8'h04);
    check({7'h00, tile_reset_q}, 8'h00);
    $display("test strap reset done");
    close_out();
  end
endmodule // tb
`default_nettype wire
